// [design/lcr_pkg.sv]
// Purpose: shared constants and carriers for the lane configuration bank
// Assumes: 125 MHz system clock, byte-wide registers
// Notes: offsets are the byte command codes seen on the serial slave
`default_nettype none
package lcr_pkg;
  // register offsets
  localparam logic [7:0] LCR_OFS_L2_DEEMPH = 8'h1F;
  localparam logic [7:0] LCR_OFS_L2_IDLE = 8'h20;
  localparam logic [7:0] LCR_OFS_GAP = 8'h21;
  localparam logic [7:0] LCR_OFS_L3_FORCE = 8'h22;
  localparam logic [7:0] LCR_OFS_L3_IDLE_TERM = 8'h23;
  localparam logic [7:0] LCR_OFS_L3_EQ = 8'h24;
  localparam logic [7:0] LCR_OFS_L3_SWING = 8'h25;
  // reset values, and the read value of unmapped offsets
  localparam logic [7:0] LCR_RST_L2_DEEMPH = 8'h02;
  localparam logic [7:0] LCR_RST_L2_IDLE = 8'h00;
  localparam logic [7:0] LCR_RST_L3_FORCE = 8'h00;
  localparam logic [7:0] LCR_RST_L3_IDLE_TERM = 8'h00;
  localparam logic [7:0] LCR_RST_L3_EQ = 8'h2F;
  localparam logic [7:0] LCR_RST_L3_SWING = 8'hAD;
  localparam logic [7:0] LCR_RD_UNMAPPED = 8'h00;
  // field positions
  localparam int LCR_BIT_PRESENCE = 7;
  localparam int LCR_RATE_HI = 6;
  localparam int LCR_RATE_LO = 5;
  localparam int LCR_DEEMPH_HI = 2;
  localparam int LCR_THR_HI = 3;
  localparam int LCR_BIT_FORCE_OFF = 2;
  localparam int LCR_BIT_FORCE_ON = 1;
  localparam int LCR_BIT_IDLE_MANUAL = 5;
  localparam int LCR_BIT_MUTE = 4;
  localparam int LCR_TERM_HI = 3;
  localparam int LCR_TERM_LO = 2;
  localparam int LCR_BIT_SHORT_PROT = 7;
  localparam int LCR_BIT_RATE_CLASS = 6;
  localparam int LCR_SWING_HI = 2;
  // termination modes and rate codes
  localparam logic [1:0] LCR_TERM_HIZ = 2'h0;
  localparam logic [1:0] LCR_TERM_LIMITED = 2'h1;
  localparam logic [1:0] LCR_TERM_ENDLESS = 2'h2;
  localparam logic [1:0] LCR_TERM_FIXED = 2'h3;
  localparam logic [1:0] LCR_RATE_BLANK = 2'h0;
  // serial slave
  localparam logic [2:0] LCR_BIT_LAST = 3'h7;
  localparam logic [6:0] LCR_DEV_ADDR = 7'h2C;
  // receiver probe timing
  localparam int unsigned LCR_CLK_KHZ = 125000;
  localparam int unsigned LCR_PROBE_PERIOD_MS = 12;
  localparam int unsigned LCR_PROBE_WINDOW_MS = 600;
  localparam int unsigned LCR_PROBE_CYCLES = LCR_PROBE_PERIOD_MS * LCR_CLK_KHZ;
  localparam int unsigned LCR_PROBE_ATTEMPTS = LCR_PROBE_WINDOW_MS / LCR_PROBE_PERIOD_MS;
  // carriers
  typedef struct packed {
    logic receiver_presence_flag;
    logic [1:0] rate_detect_flag;
  } lcr_lane2_stat_s;
  typedef struct packed {
    logic [2:0] deemphasis_level;
    logic [1:0] idle_assert_level;
    logic [1:0] idle_deassert_level;
  } lcr_lane2_cfg_s;
  typedef struct packed {
    logic sig_detect;
    logic mute;
    logic term_50;
    logic probe;
    logic [7:0] equalizer_level;
    logic short_protect;
    logic rate_class_select;
    logic [2:0] swing_level;
  } lcr_lane3_ctl_s;
endpackage
`default_nettype wire

// [design/lcr_sync.sv]
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are slow levels relative to the system clock
// Notes: only the second stage is visible outside
`timescale 1ns/100ps
`default_nettype none
module lcr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  // first stage feeds only the second; reset to the pin's idle level so no edge follows reset
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [design/lcr_termination_detect_mode.sv]
// Purpose: lane-three input termination and far-end receiver probing
// Assumes: rx_seen_in is synchronised and valid in the same cycle as probe_out
// Notes: any mode change restarts the probe sequence from scratch
`timescale 1ns/100ps
`default_nettype none
module lcr_termination_detect_mode import lcr_pkg::*; #(
  parameter int unsigned PROBE_CYCLES = LCR_PROBE_CYCLES,
  parameter int unsigned PROBE_ATTEMPTS = LCR_PROBE_ATTEMPTS
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] mode_in,
  input wire logic rx_seen_in,
  output logic term_50_out,
  output logic probe_out
);
  localparam int CW = $clog2(PROBE_CYCLES + 1);
  localparam int TW = $clog2(PROBE_ATTEMPTS + 1);
  logic [CW-1:0] tick_r;
  logic [TW-1:0] tries_r;
  logic found_r;
  logic [1:0] mode_d_r;
  // probing runs only in the two automatic modes
  wire auto_mode = (mode_in == LCR_TERM_LIMITED) | (mode_in == LCR_TERM_ENDLESS);
  wire tick_end = tick_r == CW'(PROBE_CYCLES - 1);
  wire spent = (mode_in == LCR_TERM_LIMITED) & (tries_r == TW'(PROBE_ATTEMPTS));
  wire probing = auto_mode & ~found_r & ~spent;
  wire restart = mode_in != mode_d_r;
  // period counter, attempt counter and sticky detection
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tick_r <= '0;
      tries_r <= '0;
      found_r <= 1'b0;
      mode_d_r <= LCR_TERM_HIZ;
      probe_out <= 1'b0;
      term_50_out <= 1'b0;
    end else begin
      mode_d_r <= mode_in;
      probe_out <= probing & tick_end & ~restart;
      // register mode decides termination, the pin has no say here
      term_50_out <= (mode_in == LCR_TERM_FIXED) | (auto_mode & found_r);
      if (restart) begin
        tick_r <= '0;
        tries_r <= '0;
        found_r <= 1'b0;
      end else begin
        if (probe_out && rx_seen_in) begin
          found_r <= 1'b1;
        end
        if (probing && tick_end) begin
          tick_r <= '0;
          tries_r <= tries_r + TW'(1);
        end else if (probing) begin
          tick_r <= tick_r + CW'(1);
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_PROBE_BUDGET: assert property (
    (mode_in == LCR_TERM_LIMITED) |-> (tries_r <= TW'(PROBE_ATTEMPTS)))
    else $error("limited mode exceeded its probe budget");
  AST_TERM_FIXED: assert property (
    (mode_in == LCR_TERM_FIXED) |=> term_50_out || (mode_in != LCR_TERM_FIXED))
    else $error("fixed mode did not give 50 ohm termination");
  AST_TERM_HIZ: assert property (
    (mode_in == LCR_TERM_HIZ) |=> !term_50_out && !probe_out)
    else $error("high impedance mode terminated or probed");
  AST_NO_PROBE_AFTER_FIND: assert property (
    found_r && !restart |=> !probe_out)
    else $error("probe issued after a receiver was found");
endmodule
`default_nettype wire

// [design/lcr_lane_cfg_regs.sv]
// Purpose: lane two/three configuration and status bank behind a serial slave
// Assumes: open-drain clock and data pins, 7-bit slave address
// Notes: command byte sets the pointer, each data byte moves it on by one
// Operation
// - lane-two status bit 7 shows whether a far-end receiver was detected
// - bits 6:5 report detected rate: 00 gen1, 01 gen2, 11 gen3
// - rate field meaningful only while the rate mode pin selects automatic
// - bits 2:0 choose lane-two de-emphasis, default 010
// - bits 3:2 choose idle assert threshold, default 00, override pin
// - bits 1:0 choose idle de-assert threshold, default 00, override pin
// - force-off bit drives lane-three signal detect off
// - force-on bit drives lane-three signal detect on
// - manual idle bit hands idle to the mute bit, else automatic idle
// - under manual idle, mute bit set puts the output into electrical idle
// - termination mode 00 keeps high impedance, 11 fixes 50 ohm
// - mode 01 probes every 12 ms, 50 times, 50 ohm once found
// - mode 10 probes every 12 ms until a receiver is found
// - termination mode register wins over the external termination pin
// - lane-three equalizer level is eight bits, reset 0x2F
// - swing register bit 7 enables short-circuit protection, reset 0xAD
// - bit 6 picks gen1/gen2 when set, gen3 when clear, overriding pin
// - bits 2:0 set output swing 0.7 V to 1.4 V, default 101
`timescale 1ns/100ps
`default_nettype none
module lcr_lane_cfg_regs import lcr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = LCR_DEV_ADDR,
  parameter int unsigned PROBE_CYCLES = LCR_PROBE_CYCLES,
  parameter int unsigned PROBE_ATTEMPTS = LCR_PROBE_ATTEMPTS
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic smb_scl_in,
  input wire logic smb_sda_in,
  output logic smb_sda_out,
  output logic smb_sda_oe_n_out,
  input wire lcr_lane2_stat_s lane2_stat_in,
  input wire logic rate_mode_auto_in,
  input wire logic lane3_sig_detect_in,
  input wire logic lane3_auto_idle_in,
  input wire logic lane3_rx_seen_in,
  output lcr_lane2_cfg_s lane2_cfg_out,
  output lcr_lane3_ctl_s lane3_ctl_out
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_IGNORE
  } lcr_state_e;

  localparam int SW = 9;

  // pin synchronisation
  logic [SW-1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic presence_s;
  logic [1:0] rate_s;
  logic rate_auto_s;
  logic sig_det_s;
  logic auto_idle_s;
  logic rx_seen_s;

  lcr_sync #(
    .W(SW),
    .RST_VAL({2'h3, {(SW-2){1'b0}}}) // clock and data idle high, so no false start at release
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({smb_scl_in, smb_sda_in, lane2_stat_in, rate_mode_auto_in,
               lane3_sig_detect_in, lane3_auto_idle_in, lane3_rx_seen_in}),
    .sync_out(pins_s)
  );

  assign {scl_s, sda_s, presence_s, rate_s, rate_auto_s,
          sig_det_s, auto_idle_s, rx_seen_s} = pins_s;

  // bus condition detection on synchronised levels
  logic scl_d_r;
  logic sda_d_r;
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // slave state
  lcr_state_e state_r;
  lcr_state_e state_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic hold_r;
  logic hold_nxt;
  logic low_r;
  logic low_nxt;
  logic wr_stb;

  // register contents
  logic [2:0] deemph_r;
  logic [3:0] thresh_r;
  logic [1:0] force_r;
  logic [3:0] idle_term_r;
  logic [7:0] eq_r;
  logic [7:0] swing_r;
  logic sig_det_r;
  logic mute_r;
  logic term_50;
  logic probe;

  wire [7:0] byte_in = {shift_r[6:0], sda_s};
  wire addr_hit = byte_in[7:1] == DEV_ADDR;

  // address decode shared by reads and writes
  wire hit_deemph = ptr_r == LCR_OFS_L2_DEEMPH;
  wire hit_thresh = ptr_r == LCR_OFS_L2_IDLE;
  wire hit_force = ptr_r == LCR_OFS_L3_FORCE;
  wire hit_idle_term = ptr_r == LCR_OFS_L3_IDLE_TERM;
  wire hit_eq = ptr_r == LCR_OFS_L3_EQ;
  wire hit_swing = ptr_r == LCR_OFS_L3_SWING;

  // rate code is blanked outside automatic mode so software never sees junk
  wire [1:0] rate_shown = rate_auto_s ? rate_s : LCR_RATE_BLANK;
  wire [7:0] status_byte = {presence_s, rate_shown, 2'h0, deemph_r};

  // read mux; the reserved gap and unknown offsets read zero
  wire [7:0] rd_data =
    hit_deemph ? status_byte :
    hit_thresh ? {4'h0, thresh_r} :
    hit_force ? {5'h0, force_r, 1'h0} :
    hit_idle_term ? {2'h0, idle_term_r, 2'h0} :
    hit_eq ? eq_r :
    hit_swing ? swing_r :
    LCR_RD_UNMAPPED;

  // byte engine: shift in on rising clock, drive data and ack on falling clock
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    hold_nxt = hold_r;
    low_nxt = low_r;
    wr_stb = 1'b0;
    if (bus_stop) begin
      state_nxt = ST_IDLE;
      low_nxt = 1'b0;
      hold_nxt = 1'b0;
    end else if (bus_start) begin
      state_nxt = ST_ADDR;
      cnt_nxt = '0;
      low_nxt = 1'b0;
      hold_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            shift_nxt = byte_in;
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == LCR_BIT_LAST) begin
              if (state_r == ST_ADDR) begin
                state_nxt = addr_hit ? ST_ADDR_ACK : ST_IGNORE;
              end else if (state_r == ST_CMD) begin
                ptr_nxt = byte_in;
                state_nxt = ST_CMD_ACK;
              end else begin
                wr_stb = 1'b1;
                ptr_nxt = ptr_r + 8'h01;
                state_nxt = ST_WDATA_ACK;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            hold_nxt = ~hold_r;
            low_nxt = ~hold_r;
            cnt_nxt = '0;
            if (hold_r && state_r == ST_ADDR_ACK && shift_r[0]) begin
              state_nxt = ST_RDATA;
              shift_nxt = rd_data;
              low_nxt = ~rd_data[7];
            end else if (hold_r) begin
              state_nxt = (state_r == ST_ADDR_ACK) ? ST_CMD : ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == LCR_BIT_LAST) begin
              state_nxt = ST_RDATA_ACK;
              ptr_nxt = ptr_r + 8'h01;
            end
          end else if (scl_fall) begin
            shift_nxt = {shift_r[6:0], 1'b0};
            low_nxt = ~shift_r[6];
          end
        end
        ST_RDATA_ACK: begin
          if (scl_fall && !hold_r) begin
            low_nxt = 1'b0;
            hold_nxt = 1'b1;
          end else if (scl_rise && hold_r && sda_s) begin
            state_nxt = ST_IGNORE;
            hold_nxt = 1'b0;
          end else if (scl_fall) begin
            hold_nxt = 1'b0;
            state_nxt = ST_RDATA;
            cnt_nxt = '0;
            shift_nxt = rd_data;
            low_nxt = ~rd_data[7];
          end
        end
        default: begin
          low_nxt = 1'b0;
        end
      endcase
    end
  end

  // slave flops
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      shift_r <= '0;
      ptr_r <= '0;
      hold_r <= 1'b0;
      low_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      hold_r <= hold_nxt;
      low_r <= low_nxt;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // open drain: only ever pull low, enable is active low
  assign smb_sda_out = 1'b0;
  assign smb_sda_oe_n_out = ~low_r;

  // register writes; reserved and status bits are simply not stored
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      deemph_r <= LCR_RST_L2_DEEMPH[LCR_DEEMPH_HI:0];
      thresh_r <= LCR_RST_L2_IDLE[LCR_THR_HI:0];
      force_r <= LCR_RST_L3_FORCE[LCR_BIT_FORCE_OFF:LCR_BIT_FORCE_ON];
      idle_term_r <= LCR_RST_L3_IDLE_TERM[LCR_BIT_IDLE_MANUAL:LCR_TERM_LO];
      eq_r <= LCR_RST_L3_EQ;
      swing_r <= LCR_RST_L3_SWING;
    end else if (wr_stb) begin
      if (hit_deemph) begin
        deemph_r <= byte_in[LCR_DEEMPH_HI:0];
      end else if (hit_thresh) begin
        thresh_r <= byte_in[LCR_THR_HI:0];
      end else if (hit_force) begin
        force_r <= byte_in[LCR_BIT_FORCE_OFF:LCR_BIT_FORCE_ON];
      end else if (hit_idle_term) begin
        idle_term_r <= byte_in[LCR_BIT_IDLE_MANUAL:LCR_TERM_LO];
      end else if (hit_eq) begin
        eq_r <= byte_in;
      end else if (hit_swing) begin
        swing_r <= byte_in;
      end
    end
  end

  wire force_off = force_r[1];
  wire force_on = force_r[0];
  wire idle_manual = idle_term_r[3];
  wire mute_sel = idle_term_r[2];
  wire [1:0] term_mode = idle_term_r[1:0];

  // lane-three detect and idle outputs; force-off outranks force-on
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sig_det_r <= 1'b0;
      mute_r <= 1'b0;
    end else begin
      sig_det_r <= force_off ? 1'b0 : (force_on | sig_det_s);
      mute_r <= idle_manual ? mute_sel : auto_idle_s;
    end
  end

  // receiver probing follows the register mode only, never the pin
  lcr_termination_detect_mode #(
    .PROBE_CYCLES(PROBE_CYCLES),
    .PROBE_ATTEMPTS(PROBE_ATTEMPTS)
  ) u_termination_detect_mode (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .mode_in(term_mode),
    .rx_seen_in(rx_seen_s),
    .term_50_out(term_50),
    .probe_out(probe)
  );

  // outputs gathered into carriers
  assign lane2_cfg_out = '{
    deemphasis_level: deemph_r,
    idle_assert_level: thresh_r[3:2],
    idle_deassert_level: thresh_r[1:0]
  };
  assign lane3_ctl_out = '{
    sig_detect: sig_det_r,
    mute: mute_r,
    term_50: term_50,
    probe: probe,
    equalizer_level: eq_r,
    short_protect: swing_r[LCR_BIT_SHORT_PROT],
    rate_class_select: swing_r[LCR_BIT_RATE_CLASS],
    swing_level: swing_r[LCR_SWING_HI:0]
  };

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_PRESENCE_READ: assert property (
    hit_deemph |-> rd_data[LCR_BIT_PRESENCE] == presence_s)
    else $error("presence bit does not follow the detector");
  AST_RATE_BLANK: assert property (
    hit_deemph && !rate_auto_s |-> rd_data[LCR_RATE_HI:LCR_RATE_LO] == LCR_RATE_BLANK)
    else $error("rate field shown outside automatic mode");
  AST_RATE_READ: assert property (
    hit_deemph && rate_auto_s |-> rd_data[LCR_RATE_HI:LCR_RATE_LO] == rate_s)
    else $error("rate field does not follow the detector");
  AST_DEEMPH_WRITE: assert property (
    wr_stb && hit_deemph |=> lane2_cfg_out.deemphasis_level == $past(byte_in[2:0]))
    else $error("de-emphasis write not applied");
  AST_STATUS_READONLY: assert property (
    hit_deemph |-> rd_data[4:3] == 2'h0)
    else $error("reserved status bits not zero");
  AST_THRESH_WRITE: assert property (
    wr_stb && hit_thresh |=> lane2_cfg_out.idle_assert_level == $past(byte_in[3:2])
      && lane2_cfg_out.idle_deassert_level == $past(byte_in[1:0]))
    else $error("idle threshold write not applied");
  AST_FORCE_OFF: assert property (
    force_off |=> !lane3_ctl_out.sig_detect)
    else $error("signal detect not forced off");
  AST_FORCE_ON: assert property (
    force_on && !force_off |=> lane3_ctl_out.sig_detect)
    else $error("signal detect not forced on");
  AST_MANUAL_MUTE: assert property (
    idle_manual |=> lane3_ctl_out.mute == $past(mute_sel))
    else $error("manual mute not applied");
  AST_AUTO_IDLE: assert property (
    !idle_manual |=> lane3_ctl_out.mute == $past(auto_idle_s))
    else $error("automatic idle not followed");
  AST_EQ_WRITE: assert property (
    wr_stb && hit_eq ##1 !wr_stb |=> lane3_ctl_out.equalizer_level == $past(byte_in, 2))
    else $error("equalizer write lost");
  AST_SWING_WRITE: assert property (
    wr_stb && hit_swing |=> lane3_ctl_out.swing_level == $past(byte_in[2:0])
      && lane3_ctl_out.rate_class_select == $past(byte_in[6]))
    else $error("swing register write not applied");
endmodule
`default_nettype wire

// [test/lcr_host.sv]
// Purpose: serial master host model driving the bank's clock and data pins
// Assumes: the bench resolves the open-drain data wire, pull-up when released
// Notes: each clock phase lasts 10 system clocks, above the 8 the slave needs
`timescale 1ns/100ps
`default_nettype none
module lcr_host (
  input wire logic sys_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // bus idles high, so nothing is pulled low at time zero
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_low_out <= 1'b0;
    tick(5);
    scl_out <= 1'b1;
    tick(10);
    sda_low_out <= 1'b1;
    tick(10);
    scl_out <= 1'b0;
    tick(5);
  endtask
  task automatic stop();
    sda_low_out <= 1'b1;
    tick(5);
    scl_out <= 1'b1;
    tick(10);
    sda_low_out <= 1'b0;
    tick(10);
  endtask
  // data changes only mid-low, so setup and hold both keep 5 clocks
  task automatic bit_io(input logic b, output logic s);
    sda_low_out <= ~b;
    tick(5);
    scl_out <= 1'b1;
    tick(10);
    s = sda_in;
    scl_out <= 1'b0;
    tick(5);
  endtask
  // last is sent in the ninth slot: 1 releases for the slave ack or ends a read
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, nak);
  endtask
endmodule
`default_nettype wire

// [test/lane_config_registers_tb.sv]
// Purpose: self-checking bench for the lane configuration bank
// Assumes: probe period shortened to 20 clocks and 3 attempts
// Notes: expected values come from the field layout, not from the design
`timescale 1ns/100ps
`default_nettype none
module lane_config_registers_tb import lcr_pkg::*; ();
  logic sys_clk_in;
  logic rst_n_in;
  logic scl, host_low, sda_w, sda_out, oe_n;
  lcr_lane2_stat_s stat;
  logic auto_in, sig_in, idle_in, seen_in;
  lcr_lane2_cfg_s cfg;
  lcr_lane3_ctl_s ctl;
  int failures = 0, num_checks = 0, probes = 0, base = 0;
  logic [7:0] q;
  logic n0, n1, n2;
  // offset, reset value, value written, value read back
  localparam logic [31:0] ROWS [7] = '{32'h1F02FFE7, 32'h2000FF0F, 32'h2100FF00,
    32'h2200FF06, 32'h2300FF3C, 32'h242F5555, 32'h25AD6868};
  // offset, value written, pin level, expected detect or mute
  localparam logic [23:0] PINS [9] = '{24'h220610, 24'h220201, 24'h220410, 24'h220011,
    24'h220000, 24'h233001, 24'h232010, 24'h230011, 24'h230000};
  // open drain: low if either side pulls, pull-up otherwise
  assign sda_w = !(host_low || !oe_n);
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) if (ctl.probe === 1'b1) probes <= probes + 1;
  lcr_host i_host (.sys_clk_in(sys_clk_in), .sda_in(sda_w), .scl_out(scl),
    .sda_low_out(host_low));
  lcr_lane_cfg_regs #(.PROBE_CYCLES(20), .PROBE_ATTEMPTS(3)) i_dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .smb_scl_in(scl), .smb_sda_in(sda_w),
    .smb_sda_out(sda_out), .smb_sda_oe_n_out(oe_n), .lane2_stat_in(stat),
    .rate_mode_auto_in(auto_in), .lane3_sig_detect_in(sig_in),
    .lane3_auto_idle_in(idle_in), .lane3_rx_seen_in(seen_in),
    .lane2_cfg_out(cfg), .lane3_ctl_out(ctl));
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    i_host.start();
    i_host.xfer({LCR_DEV_ADDR, 1'b0}, 1'b1, q, n0);
    i_host.xfer(ofs, 1'b1, q, n1);
    i_host.xfer(d, 1'b1, q, n2);
    i_host.stop();
    check({16'h0000, n0 | n1 | n2}, 17'h00000);
  endtask
  // the final data slot is a nack, which ends the read
  task automatic rd(input logic [7:0] ofs, output logic [7:0] r);
    i_host.start();
    i_host.xfer({LCR_DEV_ADDR, 1'b0}, 1'b1, q, n0);
    i_host.xfer(ofs, 1'b1, q, n1);
    i_host.start();
    i_host.xfer({LCR_DEV_ADDR, 1'b1}, 1'b1, q, n2);
    check({16'h0000, n0 | n1 | n2}, 17'h00000);
    i_host.xfer(8'hFF, 1'b1, r, n0);
    i_host.stop();
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // a hang is cut short well past the expected run length
  initial begin
    #400000;
    failures++;
    stop_test();
  end
  initial begin
    rst_n_in <= 1'b0;
    stat <= '0;
    auto_in <= 1'b0;
    sig_in <= 1'b0;
    idle_in <= 1'b0;
    seen_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    i_host.tick(5);
    for (int i = 0; i < 7; i++) begin
      rd(ROWS[i][31:24], q);
      check({9'h000, q}, {9'h000, ROWS[i][23:16]});
    end
    check({10'h000, cfg}, 17'h00020);
    check(ctl, {4'h0, 8'h2F, 1'b1, 1'b0, 3'h5});
    done("reset");
    stat <= 3'h7;
    auto_in <= 1'b1;
    // ones into every bit of the first five rows, 55 into the equalizer, swing row keeps 101 in 5:3
    for (int i = 0; i < 7; i++) begin
      wr(ROWS[i][31:24], ROWS[i][15:8]);
      rd(ROWS[i][31:24], q);
      check({9'h000, q}, {9'h000, ROWS[i][7:0]});
    end
    check({10'h000, cfg}, 17'h0007F);
    check(ctl, 17'h0CAA8);
    auto_in <= 1'b0;
    rd(LCR_OFS_L2_DEEMPH, q);
    check({9'h000, q}, 17'h00087);
    done("registers");
    // pins change after the write so the synchroniser delay is covered
    for (int i = 0; i < 9; i++) begin
      wr(PINS[i][23:16], PINS[i][15:8]);
      if (PINS[i][23:16] == LCR_OFS_L3_FORCE) begin
        sig_in <= PINS[i][4];
      end else begin
        idle_in <= PINS[i][4];
      end
      i_host.tick(6);
      if (PINS[i][23:16] == LCR_OFS_L3_FORCE) begin
        check({16'h0000, ctl.sig_detect}, {16'h0000, PINS[i][0]});
      end else begin
        check({16'h0000, ctl.mute}, {16'h0000, PINS[i][0]});
      end
    end
    check({16'h0000, ctl.term_50}, 17'h00000);
    done("overrides");
    base = probes;
    wr(LCR_OFS_L3_IDLE_TERM, 8'h04);
    i_host.tick(300);
    check(17'(probes - base), 17'h00003);
    check({16'h0000, ctl.term_50}, 17'h00000);
    base = probes;
    wr(LCR_OFS_L3_IDLE_TERM, 8'h08);
    i_host.tick(300);
    check({16'h0000, (probes - base) > 3}, 17'h00001);
    check({16'h0000, ctl.term_50}, 17'h00000);
    seen_in <= 1'b1;
    i_host.tick(50);
    check({16'h0000, ctl.term_50}, 17'h00001);
    done("termination");
    // reset in mid-run must bring every setting back and leave the bus released
    rst_n_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    i_host.tick(5);
    check({10'h000, cfg}, 17'h00020);
    check(ctl, {4'h0, 8'h2F, 1'b1, 1'b0, 3'h5});
    check({15'h0000, sda_out, oe_n}, 17'h00001);
    rd(LCR_OFS_L3_SWING, q);
    check({9'h000, q}, 17'h000AD);
    done("mid-run reset");
    stop_test();
  end
endmodule
`default_nettype wire
